// ==== bench/dmhp_host_model.sv ====
`timescale 1ns/1ps
module dmhp_host_model (
	input wire logic core_clk_i,
	input wire logic [7:0] dut_byte_i,
	input wire logic dut_oe_i,
	output logic [7:0] wire_o,
	output logic fetch_o,
	output logic put_o,
	output logic cs_n_o,
	output logic dc_o
);
	logic [7:0] hd = 8'h00;
	// ==========================================
	// Wire level: module while it drives, else the host pattern
	assign wire_o = dut_oe_i ? dut_byte_i : hd;
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic idle(input logic m68);
		fetch_o = !m68;
		put_o = 1'b1;
		cs_n_o = 1'b1;
		dc_o = 1'b0;
	endtask
	task automatic par_wr(input logic m68, input logic sel_n, input logic dc, input logic [7:0] b);
		cs_n_o = sel_n;
		dc_o = dc;
		hd = b;
		put_o = !m68;
		cyc(2);
		if (m68) begin
			fetch_o = 1'b1;
			cyc(2);
			fetch_o = 1'b0;
		end else begin
			put_o = 1'b0;
			cyc(2);
			put_o = 1'b1;
		end
		cyc(2);
		cs_n_o = 1'b1;
		// Released lines show the inverse, not the old byte
		hd = ~b;
		cyc(2);
	endtask
	task automatic par_rd(input logic m68, input logic dc, output logic [7:0] b);
		cs_n_o = 1'b0;
		dc_o = dc;
		put_o = 1'b1;
		cyc(1);
		fetch_o = m68;
		cyc(3);
		b = wire_o;
		fetch_o = !m68;
		cyc(2);
		cs_n_o = 1'b1;
		cyc(1);
	endtask
	task automatic ser_wr(input logic dc, input logic [7:0] b);
		cs_n_o = 1'b0;
		dc_o = dc;
		for (int i = 7; i >= 0; i--) begin
			hd = {6'h00, b[i], 1'b0};
			cyc(2);
			hd[0] = 1'b1;
			cyc(2);
		end
		hd = 8'h00;
		cyc(1);
		cs_n_o = 1'b1;
		cyc(2);
	endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	import dmhp_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] strap = DMHP_MODE_I80;
	logic host_reset_n = 1'b1;
	logic word_ready = 1'b0;
	logic [7:0] rd_byte = 8'ha5;
	logic [7:0] st_byte = 8'h5a;
	logic [7:0] lvl, dut_o, word_byte, got;
	logic oe, fetch, put, cs_n, dc, init_busy, word_valid, word_is_data;
	logic fifo_full, read_req, read_is_data;
	int n_reads = 0;
	int bad_count = 0;
	int n_compared = 0;
	dmhp_host_port #(.FIFO_DEPTH(4)) dmhp_host_port_inst (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .mode_strap_i(strap), .host_byte_lines_i(lvl),
		.host_byte_lines_o(dut_o), .host_byte_lines_oe_o(oe), .fetch_strobe_i(fetch),
		.put_strobe_i(put), .chip_sel_n_i(cs_n), .data_cmd_select_i(dc),
		.host_reset_n_i(host_reset_n), .init_busy_o(init_busy), .word_valid_o(word_valid),
		.word_ready_i(word_ready), .word_byte_o(word_byte), .word_is_data_o(word_is_data),
		.read_byte_i(rd_byte), .status_byte_i(st_byte), .read_req_o(read_req),
		.read_is_data_o(read_is_data), .fifo_full_o(fifo_full));
	always @(posedge core_clk_i) begin
		if (read_req === 1'b1) n_reads++;
	end
	dmhp_host_model dmhp_host_model_inst (.core_clk_i(core_clk_i), .dut_byte_i(dut_o),
		.dut_oe_i(oe), .wire_o(lvl), .fetch_o(fetch), .put_o(put), .cs_n_o(cs_n), .dc_o(dc));
	// ==========================================
	// Clock, closing and watchdog
	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end
	task automatic tally_and_finish();
		$display("compared=%0d failed=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk_i);
		bad_count++;
		tally_and_finish();
	end
	// ==========================================
	// Helpers
	task automatic do_reset(input logic [1:0] m);
		@(negedge core_clk_i);
		rst_i = 1'b1;
		strap = m;
		dmhp_host_model_inst.idle(m == DMHP_MODE_M68);
		repeat (12) @(negedge core_clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
	endtask
	task automatic get_word(input logic [7:0] b, input logic d);
		for (int i = 0; i < 20 && word_valid !== 1'b1; i++) @(negedge core_clk_i);
		`CHK(word_valid, 1'b1)
		`CHK(word_byte, b)
		`CHK(word_is_data, d)
		word_ready = 1'b1;
		@(negedge core_clk_i);
		word_ready = 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_i80();
		do_reset(DMHP_MODE_I80);
		strap = DMHP_MODE_M68;
		dmhp_host_model_inst.par_wr(1'b0, 1'b0, 1'b1, 8'h3c);
		get_word(8'h3c, 1'b1);
		dmhp_host_model_inst.par_wr(1'b0, 1'b0, 1'b0, 8'hc5);
		get_word(8'hc5, 1'b0);
		dmhp_host_model_inst.par_wr(1'b0, 1'b1, 1'b1, 8'h99);
		repeat (6) @(negedge core_clk_i);
		`CHK(word_valid, 1'b0)
		dmhp_host_model_inst.par_rd(1'b0, 1'b1, got);
		dmhp_host_model_inst.par_rd(1'b0, 1'b1, got);
		`CHK(got, 8'ha5)
		dmhp_host_model_inst.par_rd(1'b0, 1'b0, got);
		`CHK(got, 8'h5a)
		`CHK(read_is_data, 1'b0)
		`CHK(n_reads, 2)
	endtask
	task automatic t_pin_reset();
		host_reset_n = 1'b0;
		repeat (3) @(negedge core_clk_i);
		`CHK(init_busy, 1'b1)
		dmhp_host_model_inst.par_wr(1'b0, 1'b0, 1'b1, 8'h11);
		repeat (4) @(negedge core_clk_i);
		`CHK(word_valid, 1'b0)
		host_reset_n = 1'b1;
		repeat (3) @(negedge core_clk_i);
		`CHK(init_busy, 1'b0)
	endtask
	task automatic t_m68();
		do_reset(DMHP_MODE_M68);
		dmhp_host_model_inst.par_wr(1'b1, 1'b0, 1'b1, 8'h6b);
		get_word(8'h6b, 1'b1);
		dmhp_host_model_inst.par_rd(1'b1, 1'b1, got);
		`CHK(got, 8'ha5)
	endtask
	task automatic t_serial();
		do_reset(DMHP_MODE_SPI4);
		dmhp_host_model_inst.ser_wr(1'b1, 8'hc3);
		get_word(8'hc3, 1'b1);
		do_reset(DMHP_MODE_SPI3);
		dmhp_host_model_inst.ser_wr(1'b1, 8'h81);
		get_word(8'h81, 1'b0);
	endtask
	task automatic t_fifo();
		do_reset(DMHP_MODE_I80);
		for (int i = 0; i < 6; i++) dmhp_host_model_inst.par_wr(1'b0, 1'b0, 1'b1, 8'h10 + 8'(i));
		`CHK(fifo_full, 1'b1)
		for (int i = 0; i < 5; i++) get_word(8'h10 + 8'(i), 1'b1);
		repeat (4) @(negedge core_clk_i);
		`CHK(word_valid, 1'b0)
		`CHK(fifo_full, 1'b0)
	endtask
	initial begin
		dmhp_host_model_inst.idle(1'b0);
		t_i80();
		t_pin_reset();
		t_m68();
		t_serial();
		t_fifo();
		tally_and_finish();
	end
endmodule

// ==== include/dmhp_pkg.sv ====
package dmhp_pkg;

	// ==========================================
	// Interface modes, selected by the two straps {mode_strap_b, mode_strap_a}
	typedef enum logic [1:0] {
		DMHP_MODE_I80 = 2'b00,
		DMHP_MODE_M68 = 2'b01,
		DMHP_MODE_SPI3 = 2'b10,
		DMHP_MODE_SPI4 = 2'b11
	} dmhp_mode_t;

	// ==========================================
	// Widths and depths
	localparam int DMHP_BYTE_W = 8;
	localparam int DMHP_WORD_W = 9;
	localparam int DMHP_FIFO_DEPTH = 16;
	localparam int DMHP_BIT_CNT_W = 3;
	localparam logic [2:0] DMHP_LAST_BIT = 3'h7;

	// ==========================================
	// Pin positions on the byte lines in serial mode
	localparam int DMHP_SCLK_BIT = 0;
	localparam int DMHP_SERIAL_IN_LINE_BIT = 1;

	// ==========================================
	// Reset values
	localparam logic [7:0] DMHP_BYTE_RST = 8'h00;
	localparam logic [7:0] DMHP_STATUS_RST = 8'h00;
	localparam logic [2:0] DMHP_BIT_RST = 3'h0;

endpackage

// ==== rtl/dmhp_fifo.sv ====
`timescale 1ns/1ps
module dmhp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;
	logic full;
	logic empty;

	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = (wr_ptr == rd_ptr);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr[AW-1:0]];
	assign push = in_valid_i && !full;
	assign pop = out_ready_i && !empty;

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

// ==== rtl/dmhp_host_port.sv ====
`timescale 1ns/1ps
module dmhp_host_port
	import dmhp_pkg::*;
#(
	parameter int FIFO_DEPTH = DMHP_FIFO_DEPTH
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [1:0] mode_strap_i,
	input wire logic [7:0] host_byte_lines_i,
	output logic [7:0] host_byte_lines_o,
	output logic host_byte_lines_oe_o,
	input wire logic fetch_strobe_i,
	input wire logic put_strobe_i,
	input wire logic chip_sel_n_i,
	input wire logic data_cmd_select_i,
	input wire logic host_reset_n_i,
	output logic init_busy_o,
	output logic word_valid_o,
	input wire logic word_ready_i,
	output logic [7:0] word_byte_o,
	output logic word_is_data_o,
	input wire logic [7:0] read_byte_i,
	input wire logic [7:0] status_byte_i,
	output logic read_req_o,
	output logic read_is_data_o,
	output logic fifo_full_o
);
	// ==========================================
	// Strap capture and pin decode
	dmhp_mode_t mode;
	logic strap_taken;
	logic fetch_q;
	logic put_q;
	logic sclk_q;
	logic sel;
	logic m68_en_fall;
	logic m68_en_rise;
	logic i80_rd_fall;
	logic i80_wr_fall;
	logic sclk_rise;
	logic serial_mode;
	logic [2:0] bit_cnt;
	logic [6:0] shift;
	logic wr_strobe;
	logic [7:0] wr_byte;
	logic wr_dc;
	logic rd_strobe;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [8:0] fifo_out_data;
	logic pop;

	// Strap level taken once, at the first clock after reset release
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode <= DMHP_MODE_I80;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			mode <= dmhp_mode_t'(mode_strap_i);
			strap_taken <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fetch_q <= 1'b0;
			put_q <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			fetch_q <= fetch_strobe_i;
			put_q <= put_strobe_i;
			sclk_q <= host_byte_lines_i[DMHP_SCLK_BIT];
		end
	end

	assign sel = !chip_sel_n_i && host_reset_n_i && strap_taken;
	assign serial_mode = (mode == DMHP_MODE_SPI3) || (mode == DMHP_MODE_SPI4);
	assign m68_en_rise = (mode == DMHP_MODE_M68) && sel && fetch_strobe_i && !fetch_q;
	assign m68_en_fall = (mode == DMHP_MODE_M68) && sel && !fetch_strobe_i && fetch_q;
	assign i80_rd_fall = (mode == DMHP_MODE_I80) && sel && !fetch_strobe_i && fetch_q;
	assign i80_wr_fall = (mode == DMHP_MODE_I80) && sel && !put_strobe_i && put_q;
	assign sclk_rise = serial_mode && sel && host_byte_lines_i[DMHP_SCLK_BIT] && !sclk_q;

	// ==========================================
	// Serial shifter, MSB first
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_cnt <= DMHP_BIT_RST;
			shift <= '0;
		end else if (!sel) begin
			bit_cnt <= DMHP_BIT_RST;
		end else if (sclk_rise) begin
			shift <= {shift[5:0], host_byte_lines_i[DMHP_SERIAL_IN_LINE_BIT]};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// ==========================================
	// Write path: one strobe per accepted byte
	always_comb begin
		wr_strobe = 1'b0;
		wr_byte = host_byte_lines_i;
		wr_dc = data_cmd_select_i;
		unique case (mode)
			DMHP_MODE_M68: begin
				wr_strobe = m68_en_fall && !put_strobe_i;
			end
			DMHP_MODE_I80: begin
				wr_strobe = i80_wr_fall;
			end
			DMHP_MODE_SPI3, DMHP_MODE_SPI4: begin
				wr_strobe = sclk_rise && (bit_cnt == DMHP_LAST_BIT);
				wr_byte = {shift, host_byte_lines_i[DMHP_SERIAL_IN_LINE_BIT]};
				// Three-wire has no select pin; bytes go to the command path
				wr_dc = (mode == DMHP_MODE_SPI4) && data_cmd_select_i;
			end
		endcase
	end

	dmhp_fifo #(
		.WIDTH(DMHP_WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(wr_strobe),
		.in_ready_o(fifo_in_ready),
		.in_data_i({wr_dc, wr_byte}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_out_data)
	);

	// Output stage register; FIFO drains only when it is free
	assign pop = fifo_out_valid && (!word_valid_o || word_ready_i) && host_reset_n_i;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			word_valid_o <= 1'b0;
			word_byte_o <= DMHP_BYTE_RST;
			word_is_data_o <= 1'b0;
			fifo_full_o <= 1'b0;
			init_busy_o <= 1'b1;
		end else begin
			fifo_full_o <= !fifo_in_ready;
			init_busy_o <= !host_reset_n_i;
			if (!host_reset_n_i) begin
				word_valid_o <= 1'b0;
			end else if (pop) begin
				word_valid_o <= 1'b1;
				word_byte_o <= fifo_out_data[7:0];
				word_is_data_o <= fifo_out_data[8];
			end else if (word_ready_i) begin
				word_valid_o <= 1'b0;
			end
		end
	end

	// ==========================================
	// Read path: host owns the lines except during a selected read
	assign rd_strobe = (m68_en_rise && put_strobe_i) || i80_rd_fall;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			read_req_o <= 1'b0;
			read_is_data_o <= 1'b0;
			host_byte_lines_o <= DMHP_BYTE_RST;
			host_byte_lines_oe_o <= 1'b0;
		end else begin
			read_req_o <= rd_strobe && data_cmd_select_i;
			read_is_data_o <= data_cmd_select_i;
			if (rd_strobe) begin
				// Display data comes from the pipelined latch, hence the dummy read
				host_byte_lines_o <= data_cmd_select_i ? read_byte_i : status_byte_i;
				host_byte_lines_oe_o <= 1'b1;
			end else if (!sel || serial_mode
				|| (mode == DMHP_MODE_M68 && !fetch_strobe_i)
				|| (mode == DMHP_MODE_I80 && fetch_strobe_i)) begin
				host_byte_lines_oe_o <= 1'b0;
			end
		end
	end

	// ==========================================
	// Checks
	sequence s_m68_write;
		$fell(fetch_strobe_i) && !put_strobe_i && sel && mode == DMHP_MODE_M68;
	endsequence

	a_no_drive_unselected: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(chip_sel_n_i) |=> !host_byte_lines_oe_o)
		else $error("byte lines driven after deselect");
	a_serial_no_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
		serial_mode |-> ##1 !host_byte_lines_oe_o)
		else $error("byte lines driven in serial mode");
	a_m68_write_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_m68_write |-> wr_strobe)
		else $error("6800 write not latched on enable fall");
	a_m68_read_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(m68_en_rise && put_strobe_i) |=> host_byte_lines_oe_o)
		else $error("6800 read not driven");
	a_i80_read_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
		i80_rd_fall |=> host_byte_lines_oe_o && host_byte_lines_o == $past(
		data_cmd_select_i ? read_byte_i : status_byte_i))
		else $error("8080 read byte wrong");
	a_i80_write_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
		i80_wr_fall |-> wr_strobe && wr_byte == host_byte_lines_i)
		else $error("8080 write missed");
	a_mode_fixed: assert property (@(posedge core_clk_i) disable iff (rst_i)
		strap_taken ##1 1 |-> $stable(mode))
		else $error("mode changed at run time");
	a_reset_busy: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!host_reset_n_i |=> init_busy_o && !word_valid_o)
		else $error("reset pin not honoured");
	a_serial_byte: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(sclk_rise && bit_cnt == DMHP_LAST_BIT) |-> wr_strobe
		&& wr_byte[0] == host_byte_lines_i[DMHP_SERIAL_IN_LINE_BIT])
		else $error("serial byte not completed");
	a_data_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(pop && host_reset_n_i) |=> word_valid_o
		&& word_is_data_o == $past(fifo_out_data[8]))
		else $error("data/command flag lost");
	a_cmd_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(i80_wr_fall && !data_cmd_select_i) |-> !wr_dc)
		else $error("command byte marked as data");

	// ==========================================
	// Sequences for the stream checks
	sequence s_i80_write;
		$fell(put_strobe_i) && sel && mode == DMHP_MODE_I80;
	endsequence

	sequence s_serial_last;
		sclk_rise && bit_cnt == DMHP_LAST_BIT;
	endsequence

	sequence s_read_start;
		rd_strobe;
	endsequence

	// ==========================================
	// Select and pin reset gating
	a_unsel_no_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!sel |-> !wr_strobe)
		else $error("write taken while unselected");
	a_unsel_no_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!sel |=> !read_req_o)
		else $error("read taken while unselected");
	a_reset_no_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!host_reset_n_i |-> !wr_strobe)
		else $error("write taken during pin reset");
	a_busy_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		host_reset_n_i |=> !init_busy_o)
		else $error("busy flag stuck after pin reset");

	// ==========================================
	// Write stream
	a_i80_write_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_i80_write |-> wr_strobe && wr_dc == data_cmd_select_i)
		else $error("8080 write flag wrong");
	a_spi3_cmd: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_serial_last ##0 (mode == DMHP_MODE_SPI3) |-> !wr_dc)
		else $error("three-wire byte marked as data");
	a_spi4_dc_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_serial_last ##0 (mode == DMHP_MODE_SPI4) |-> wr_dc == data_cmd_select_i)
		else $error("four-wire flag wrong");
	a_serial_no_par: assert property (@(posedge core_clk_i) disable iff (rst_i)
		serial_mode |-> !(m68_en_fall || i80_wr_fall || rd_strobe))
		else $error("parallel strobe taken in serial mode");
	a_partial_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!sel |=> bit_cnt == DMHP_BIT_RST)
		else $error("partial serial byte kept");
	a_bit_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
		sclk_rise |=> bit_cnt == $past(bit_cnt) + 3'h1)
		else $error("serial bit count wrong");
	a_m68_read_nopush: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(m68_en_fall && put_strobe_i) |-> !wr_strobe)
		else $error("6800 read taken as write");
	a_full_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!fifo_in_ready |=> fifo_full_o)
		else $error("full flag missed");
	a_word_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(word_valid_o && !word_ready_i && host_reset_n_i) |=> word_valid_o
		&& $stable(word_byte_o))
		else $error("output word changed before taken");

	// ==========================================
	// Read path
	a_m68_write_nodrive: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(m68_en_rise && !put_strobe_i) |=> !host_byte_lines_oe_o)
		else $error("byte lines driven on 6800 write");
	a_read_req_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_read_start ##0 data_cmd_select_i |=> read_req_o)
		else $error("display read not reported");
	a_status_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rd_strobe && !data_cmd_select_i) |=> host_byte_lines_o == $past(status_byte_i))
		else $error("status byte wrong");
	a_m68_read_byte: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(m68_en_rise && put_strobe_i && data_cmd_select_i)
		|=> host_byte_lines_o == $past(read_byte_i))
		else $error("6800 read byte wrong");
	a_i80_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(mode == DMHP_MODE_I80 && fetch_strobe_i) |=> !host_byte_lines_oe_o)
		else $error("byte lines held after 8080 read");
	a_m68_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(mode == DMHP_MODE_M68 && !fetch_strobe_i) |=> !host_byte_lines_oe_o)
		else $error("byte lines held after 6800 read");

	// ==========================================
	// Strap capture
	a_mode_taken: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(strap_taken) |-> mode == $past(mode_strap_i))
		else $error("strap level not captured");
endmodule
